// ---- cell_pkg.sv ----
package cell_pkg;

  // register bus shape
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // register byte addresses
  localparam logic [ADDR_W-1:0] CONFIG_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] LUT_ADDR    = 4'h4;
  localparam logic [ADDR_W-1:0] PLACE_ADDR  = 4'h8;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'hC;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // chain geometry: eight cells to a group, long chains skip one group
  localparam logic [2:0] FIRST_POS  = 3'h0;
  localparam logic [4:0] GROUP_SKIP = 5'h02;

  typedef enum logic [1:0] {MODE_NORMAL, MODE_ARITH, MODE_UPDOWN, MODE_CLRCNT} cell_mode_t;
  typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} ff_kind_t;
  typedef enum logic [1:0] {SRC_GLOBAL, SRC_IO, SRC_LOGIC, SRC_TIED} ctrl_src_t;

  // configuration word, low bits of CONFIG
  typedef struct packed {
    cell_mode_t mode;
    ff_kind_t   ff_kind;
    ctrl_src_t  clk_src;
    ctrl_src_t  clr_src;
    ctrl_src_t  pre_src;
    logic       bypass;
    logic       pack;
    logic       swap;
    logic       local_reg;
    logic       route_reg;
    logic       carry_as_in3;
    logic       cascade_or;
    logic       ce_from_one;
  } cell_cfg_t;

  // placement word, low bits of PLACE
  typedef struct packed {
    logic [4:0] mem_group;
    logic [4:0] group;
    logic [2:0] pos;
  } cell_place_t;

  localparam int CFG_W   = $bits(cell_cfg_t);
  localparam int PLACE_W = $bits(cell_place_t);
  localparam int LUT_W   = 16;

  // reset values
  localparam cell_cfg_t   CFG_RESET   = cell_cfg_t'(18'h00000);
  localparam cell_place_t PLACE_RESET = cell_place_t'(13'h0000);
  localparam logic [LUT_W-1:0] LUT_RESET = 16'h0000;

endpackage : cell_pkg

// ---- logic_cell.sv ----
// Behaviour
// - register acts as D, T, JK or SR; clock, clear, preset sources selectable.
// - combinational use bypasses the register, table result drives the outputs.
// - local and routing outputs each pick table result or register value.
// - carry-in feeds both the table and the carry-out logic.
// - carry chains longer than a group jump to the group two further on.
// - carry chain restarts past the embedded memory block mid-row.
// - n-bit adder in n+1 cells; sum register optional or accumulating.
// - cascade joins table output and cascade-in by AND, or OR by inversion.
// - every cascaded cell adds four inputs to the wide function.
// - cascade chains longer than a group jump to the group two further on.
// - cascade chain restarts past the embedded memory block mid-row.
// - four modes: normal, arithmetic, up/down counter, clearable counter.
// - four logic inputs plus clock, clear and preset controls.
// - synchronous clock enable in every mode, optionally from input one.
// - normal mode table takes carry-in or input three as third input.
// - normal mode feeds cascade-out; register or table may drive both outputs.
// - packing loads input four into register; outputs may be swapped.
// - a packed cell keeps out of the cascade chain.
// - arithmetic mode: two three-input functions give sum and carry-out.
// - up/down counter with enable, direction, and 2-to-1 synchronous load.
// - counter register also loadable through clear and preset.
// - clearable counter ANDs load mux output with clear taken from cascade-in.
// - clear and preset are active low; unused ones read high.
// - device-wide reset clears the register over every other control.
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
module logic_cell
(
  // clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rstn,
  input  wire logic                        chip_reset_n,
  // axi4-lite write address and data
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [cell_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                        wvalid,
  output logic                             wready,
  input  wire logic [cell_pkg::DATA_W-1:0] wdata,
  input  wire logic [3:0]                  wstrb,
  // axi4-lite write response
  output logic                             bvalid,
  input  wire logic                        bready,
  output logic [1:0]                       bresp,
  // axi4-lite read
  input  wire logic                        arvalid,
  output logic                             arready,
  input  wire logic [cell_pkg::ADDR_W-1:0] araddr,
  output logic                             rvalid,
  input  wire logic                        rready,
  output logic [cell_pkg::DATA_W-1:0]      rdata,
  output logic [1:0]                       rresp,
  // data inputs
  input  wire logic                        cell_input_one,
  input  wire logic                        cell_input_two,
  input  wire logic                        cell_input_three,
  input  wire logic                        cell_input_four,
  // control sources for clock, clear and preset
  input  wire logic                        ctrl_global,
  input  wire logic                        ctrl_io,
  input  wire logic                        ctrl_logic,
  // chains from the cell below and from two groups back
  input  wire logic                        carry_in_near,
  input  wire logic                        carry_in_far,
  input  wire logic                        cascade_in_near,
  input  wire logic                        cascade_in_far,
  // cell outputs
  output logic                             local_out,
  output logic                             route_out,
  output logic                             carry_out,
  output logic                             cascade_out
);

  // 16-entry table lookup
  function automatic logic lut_pick(input logic [cell_pkg::LUT_W-1:0] mask,
                                    input logic [3:0] idx);
    lut_pick = mask[idx];
  endfunction : lut_pick

  // chain entry: first cell of a group takes the far link unless a chain starts here
  function automatic logic chain_entry(input cell_pkg::cell_place_t pl,
                                       input logic near, input logic far,
                                       input logic start_val);
    logic [5:0] past_mem;
    past_mem = {1'b0, pl.mem_group} + {1'b0, cell_pkg::GROUP_SKIP};
    if (pl.pos != cell_pkg::FIRST_POS)
      chain_entry = near;
    else if (pl.group < cell_pkg::GROUP_SKIP)
      chain_entry = start_val;
    else if (pl.group >= pl.mem_group && {1'b0, pl.group} < past_mem)
      chain_entry = start_val;
    else
      chain_entry = far;
  endfunction : chain_entry

  // pick a control source; tied reads high so an unused low-active control is idle
  function automatic logic src_pick(input cell_pkg::ctrl_src_t sel, input logic g,
                                    input logic io, input logic lg);
    case (sel)
      cell_pkg::SRC_GLOBAL: src_pick = g;
      cell_pkg::SRC_IO:     src_pick = io;
      cell_pkg::SRC_LOGIC:  src_pick = lg;
      default:              src_pick = 1'b1;
    endcase
  endfunction : src_pick

  // byte-lane merge for register writes
  function automatic logic [cell_pkg::DATA_W-1:0] merge(input logic [cell_pkg::DATA_W-1:0] old,
                                                        input logic [cell_pkg::DATA_W-1:0] nw,
                                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
  endfunction : merge

  cell_pkg::cell_cfg_t         cfg_reg;
  cell_pkg::cell_place_t       place_reg;
  logic [cell_pkg::LUT_W-1:0]  lut_reg;
  logic                        q_reg;
  logic                        clk_level_reg;
  logic [cell_pkg::ADDR_W-1:0] aw_addr_reg;
  logic [cell_pkg::DATA_W-1:0] w_data_reg;
  logic [3:0]                  w_strb_reg;
  logic                        wr_fire;
  logic                        carry_in;
  logic                        cascade_in;
  logic                        in3;
  logic                        lut4;
  logic                        sum3;
  logic                        carry3;
  logic                        count_next;
  logic                        load_mux;
  logic                        comb;
  logic                        cas;
  logic                        ff_d;
  logic                        carry_next;
  logic                        q_next;
  logic                        clk_src_lvl;
  logic                        tick;
  logic                        ce;
  logic                        clr_n;
  logic                        pre_n;
  logic                        local_next;
  logic                        route_next;
  logic [cell_pkg::DATA_W-1:0] status_word;

  // write address channel: one address held until the response is taken
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      awready     <= 1'b1;
      aw_addr_reg <= 4'h0;
    end
    else if (awvalid && awready)
    begin
      awready     <= 1'b0;
      aw_addr_reg <= awaddr;
    end
    else if (bvalid && bready)
      awready <= 1'b1;
  end

  // write data channel, independent of the address so either may come first
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      wready     <= 1'b1;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end
    else if (wvalid && wready)
    begin
      wready     <= 1'b0;
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
    end
    else if (bvalid && bready)
      wready <= 1'b1;
  end

  // both halves held and no answer pending: commit exactly once
  assign wr_fire = !awready && !wready && !bvalid;

  // write response, slverr for unmapped or read-only addresses
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      bvalid <= 1'b0;
      bresp  <= cell_pkg::RESP_OKAY;
    end
    else if (bvalid && bready)
      bvalid <= 1'b0;
    else if (wr_fire)
    begin
      bvalid <= 1'b1;
      if (aw_addr_reg == cell_pkg::CONFIG_ADDR || aw_addr_reg == cell_pkg::LUT_ADDR
          || aw_addr_reg == cell_pkg::PLACE_ADDR)
        bresp <= cell_pkg::RESP_OKAY;
      else
        bresp <= cell_pkg::RESP_SLVERR;
    end
  end

  // configuration registers
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_reg   <= cell_pkg::CFG_RESET;
      lut_reg   <= cell_pkg::LUT_RESET;
      place_reg <= cell_pkg::PLACE_RESET;
    end
    else if (wr_fire)
    begin
      if (aw_addr_reg == cell_pkg::CONFIG_ADDR)
        cfg_reg <= cell_pkg::cell_cfg_t'(cell_pkg::CFG_W'(
                     merge(32'(cfg_reg), w_data_reg, w_strb_reg)));
      else if (aw_addr_reg == cell_pkg::LUT_ADDR)
        lut_reg <= cell_pkg::LUT_W'(merge(32'(lut_reg), w_data_reg, w_strb_reg));
      else if (aw_addr_reg == cell_pkg::PLACE_ADDR)
        place_reg <= cell_pkg::cell_place_t'(cell_pkg::PLACE_W'(
                       merge(32'(place_reg), w_data_reg, w_strb_reg)));
    end
  end

  // live cell state for software
  assign status_word = {27'h0000000, cascade_out, carry_out, route_out, local_out, q_reg};

  // read channel: data captured at the address handshake, answered next cycle
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= cell_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= cell_pkg::RESP_OKAY;
      if (araddr == cell_pkg::CONFIG_ADDR)
        rdata <= 32'(cfg_reg);
      else if (araddr == cell_pkg::LUT_ADDR)
        rdata <= 32'(lut_reg);
      else if (araddr == cell_pkg::PLACE_ADDR)
        rdata <= 32'(place_reg);
      else if (araddr == cell_pkg::STATUS_ADDR)
        rdata <= status_word;
      else
      begin
        rdata <= 32'h0000_0000;
        rresp <= cell_pkg::RESP_SLVERR;
      end
    end
    else if (rvalid && rready)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // chain entry; a cascade starts at its identity value, AND 1 or OR 0
  assign carry_in   = chain_entry(place_reg, carry_in_near, carry_in_far, 1'b0);
  assign cascade_in = chain_entry(place_reg, cascade_in_near, cascade_in_far,
                                  !cfg_reg.cascade_or);

  // table views: one four-input function or two three-input halves
  assign in3    = cfg_reg.carry_as_in3 ? carry_in : cell_input_three;
  assign lut4   = lut_pick(lut_reg, {cell_input_four, in3, cell_input_two, cell_input_one});
  assign sum3   = lut_pick(lut_reg, {1'b0, carry_in, cell_input_two, cell_input_one});
  assign carry3 = lut_pick(lut_reg, {1'b1, carry_in, cell_input_two, cell_input_one});

  // mode datapath
  always_comb
  begin
    comb       = lut4;
    cas        = lut4;
    ff_d       = lut4;
    carry_next = 1'b0;
    count_next = q_reg ^ carry_in; // toggles when the lower bits roll over
    load_mux   = cell_input_four ? cell_input_two : count_next;
    case (cfg_reg.mode)
      cell_pkg::MODE_NORMAL:
      begin
        if (cfg_reg.pack)
        begin
          cas  = lut4;
          ff_d = cell_input_four;
        end
        else
        begin
          cas  = cfg_reg.cascade_or ? (lut4 | cascade_in) : (lut4 & cascade_in);
          ff_d = cas;
        end
      end
      cell_pkg::MODE_ARITH:
      begin
        cas        = cfg_reg.cascade_or ? (sum3 | cascade_in) : (sum3 & cascade_in);
        comb       = sum3;
        ff_d       = sum3;
        carry_next = carry3;
      end
      cell_pkg::MODE_UPDOWN:
      begin
        comb       = count_next;
        cas        = count_next;
        ff_d       = load_mux;
        // borrow ripples through zeros when counting down
        carry_next = cell_input_three ? (q_reg & carry_in) : (!q_reg & carry_in);
      end
      default:
      begin
        comb       = count_next;
        cas        = count_next;
        ff_d       = load_mux & cascade_in;
        carry_next = q_reg & carry_in;
      end
    endcase
  end

  // register next state; counter modes always load as d
  always_comb
  begin
    q_next = ff_d;
    if (cfg_reg.mode == cell_pkg::MODE_NORMAL || cfg_reg.mode == cell_pkg::MODE_ARITH)
    begin
      case (cfg_reg.ff_kind)
        cell_pkg::FF_D:  q_next = ff_d;
        cell_pkg::FF_T:  q_next = q_reg ^ ff_d;
        cell_pkg::FF_JK: q_next = (ff_d & !q_reg) | (!cell_input_two & q_reg);
        default:         q_next = ff_d ? 1'b1 : (cell_input_two ? 1'b0 : q_reg);
      endcase
    end
  end

  // control selection; the cell clock is a rising-edge enable on mclk
  assign clk_src_lvl = src_pick(cfg_reg.clk_src, ctrl_global, ctrl_io, ctrl_logic);
  assign tick        = clk_src_lvl && !clk_level_reg;
  assign ce          = cfg_reg.ce_from_one ? cell_input_one : 1'b1;
  assign clr_n       = src_pick(cfg_reg.clr_src, ctrl_global, ctrl_io, ctrl_logic);
  assign pre_n       = src_pick(cfg_reg.pre_src, ctrl_global, ctrl_io, ctrl_logic);

  // previous level of the selected cell clock
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      clk_level_reg <= 1'b0;
    else
      clk_level_reg <= clk_src_lvl;
  end

  // cell register: device reset, then clear, then preset, then enabled clock
  // clear and preset act on any mclk edge, not waiting for the cell clock
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      q_reg <= 1'b0;
    else if (!chip_reset_n)
      q_reg <= 1'b0;
    else if (!clr_n)
      q_reg <= 1'b0;
    else if (!pre_n)
      q_reg <= 1'b1;
    else if (tick && ce)
      q_reg <= q_next;
  end

  // output selection; bypass makes the cell purely combinational
  always_comb
  begin
    local_next = (cfg_reg.local_reg && !cfg_reg.bypass) ? q_reg : comb;
    route_next = (cfg_reg.route_reg && !cfg_reg.bypass) ? q_reg : comb;
    if (cfg_reg.pack && cfg_reg.swap)
      {local_next, route_next} = {route_next, local_next};
  end

  // outputs retimed on mclk, one cycle behind their inputs
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      local_out   <= 1'b0;
      route_out   <= 1'b0;
      carry_out   <= 1'b0;
      cascade_out <= 1'b0;
    end
    else
    begin
      local_out   <= local_next;
      route_out   <= route_next;
      carry_out   <= carry_next;
      cascade_out <= cas;
    end
  end

endmodule : logic_cell

// ---- logic_cell_assertions.sv ----
module cell_checker
(
  // clock and resets
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        chip_reset_n,
  // register bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [3:0]  awaddr,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [31:0] wdata,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  // cell side
  input wire logic        ctrl_logic,
  input wire logic        local_out,
  input wire logic        carry_out
);
  cell_pkg::cell_cfg_t cfg_seen;
  logic                reg_view;

  // config shadow; the bench offers address and data together
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      cfg_seen <= cell_pkg::CFG_RESET;
    else if (awvalid && awready && wvalid && wready && awaddr == cell_pkg::CONFIG_ADDR)
      cfg_seen <= cell_pkg::cell_cfg_t'(wdata[cell_pkg::CFG_W-1:0]);
  end

  // local output shows the register
  assign reg_view = cfg_seen.local_reg && !cfg_seen.bypass && !(cfg_seen.pack && cfg_seen.swap);

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_r_answer;
    arvalid && arready |=> rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");

  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");

  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");

  property p_ar_busy;
    rvalid |-> !arready;
  endproperty
  a_ar_busy: assert property (p_ar_busy) else $error("read taken while busy");

  property p_aw_busy;
    bvalid |-> !awready && !wready;
  endproperty
  a_aw_busy: assert property (p_aw_busy) else $error("write taken while busy");

  property p_ro_write;
    awvalid && awready && wvalid && wready && awaddr == cell_pkg::STATUS_ADDR
      |-> ##[1:3] (bvalid && bresp == cell_pkg::RESP_SLVERR);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("status write not refused");

  property p_clear_low;
    (chip_reset_n && !ctrl_logic && reg_view && cfg_seen.clr_src == cell_pkg::SRC_LOGIC)[*6]
      |-> !local_out;
  endproperty
  a_clear_low: assert property (p_clear_low) else $error("low clear ignored");

  property p_chip_reset;
    (!chip_reset_n && reg_view)[*6] |-> !local_out;
  endproperty
  a_chip_reset: assert property (p_chip_reset) else $error("chip reset lost");

  property p_normal_carry;
    (cfg_seen.mode == cell_pkg::MODE_NORMAL)[*6] |-> !carry_out;
  endproperty
  a_normal_carry: assert property (p_normal_carry) else $error("carry in normal mode");
endmodule : cell_checker

bind logic_cell cell_checker i_cell_checker
(
  .mclk, .rstn, .chip_reset_n, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
  .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .ctrl_logic,
  .local_out, .carry_out
);

// ---- chain_neighbours.sv ----
module chain_neighbours
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // levels the bench asks the neighbours to launch
  input  wire logic [3:0] chain_cmd,
  // {cascade far, cascade near, carry far, carry near}
  output logic      [3:0] chain_lines
);
  timeunit 1ns;
  timeprecision 1ns;

  // neighbours launch from flops, so values arrive one mclk late
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      chain_lines <= 4'h0;
    else
      chain_lines <= chain_cmd;
  end
endmodule : chain_neighbours

// ---- programmable_logic_cell_test.sv ----
module programmable_logic_cell_test;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [1:0]  OK  = cell_pkg::RESP_OKAY;
  localparam logic [1:0]  ERR = cell_pkg::RESP_SLVERR;
  logic mclk = 1'h0, rstn = 1'h0, chip_reset_n = 1'h1;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF, din = 4'h0, chain_cmd = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic ctrl_global = 1'h0, ctrl_io = 1'h1, ctrl_logic = 1'h1;
  logic awready, wready, bvalid, arready, rvalid, local_out, route_out, carry_out, cascade_out;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, v;
  logic [3:0] chain_lines, ad[3], d, ch;
  logic [31:0] mk[3];
  logic [10:0] ptab[6];
  logic [15:0] lut;
  logic q, o;
  int failures = 0, cmp_count = 0, i, j, k;

  always #25 mclk = ~mclk;

  chain_neighbours i_chain_neighbours (.mclk, .rstn, .chain_cmd, .chain_lines);

  logic_cell i_logic_cell (.mclk, .rstn, .chip_reset_n, .awvalid, .awready, .awaddr, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready, .rdata, .rresp, .cell_input_one(din[0]), .cell_input_two(din[1]),
    .cell_input_three(din[2]), .cell_input_four(din[3]), .ctrl_global, .ctrl_io, .ctrl_logic,
    .carry_in_near(chain_lines[0]), .carry_in_far(chain_lines[1]),
    .cascade_in_near(chain_lines[2]), .cascade_in_far(chain_lines[3]), .local_out, .route_out,
    .carry_out, .cascade_out);

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic chb(input string nm, input logic ex, input logic got);
    chk(nm, 32'(ex), 32'(got));
  endtask : chb

  // each channel held until taken; bready up until the answer
  task automatic wr(input logic [3:0] a, input logic [31:0] dt, input logic [1:0] er);
    int n;
    @(posedge mclk);
    awaddr <= a; wdata <= dt; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid === 1'h1)
      begin
        chk("bresp", 32'(er), 32'(bresp));
        bready <= 1'h0;
        break;
      end
    end
    if (n == 40) chk("write answer", 32'h1, 32'h0);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] ex, input logic [1:0] er,
                    input logic [31:0] m);
    int n;
    @(posedge mclk);
    araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid === 1'h1)
      begin
        chk("rdata", ex, rdata & m);
        chk("rresp", 32'(er), 32'(rresp));
        rready <= 1'h0;
        break;
      end
    end
    if (n == 40) chk("read answer", 32'h1, 32'h0);
  endtask : rd

  // off-edge wait so outputs are sampled settled
  task automatic settle;
    repeat (5) @(posedge mclk);
    #5;
  endtask : settle

  task automatic setin(input logic [3:0] dd, input logic [3:0] cc);
    @(posedge mclk);
    din <= dd; chain_cmd <= cc;
    settle();
  endtask : setin

  // one rising edge of the io clock source
  task automatic tick;
    @(posedge mclk);
    ctrl_io <= 1'h0;
    repeat (3) @(posedge mclk);
    ctrl_io <= 1'h1;
    settle();
  endtask : tick

  function automatic logic [31:0] cf(input logic [1:0] md, input logic [1:0] cl,
                                     input logic [1:0] pr, input logic [7:0] b);
    return {14'h0, md, 2'h0, 2'h1, cl, pr, b};
  endfunction : cf

  function automatic logic [31:0] pl(input logic [4:0] m, input logic [4:0] g,
                                     input logic [2:0] p);
    return {19'h0, m, g, p};
  endfunction : pl

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  initial
  begin
    repeat (10000) @(posedge mclk);
    failures++;
    close_out();
  end

  initial
  begin
    ad = '{cell_pkg::CONFIG_ADDR, cell_pkg::LUT_ADDR, cell_pkg::PLACE_ADDR};
    mk = '{32'h3FFFF, 32'hFFFF, 32'h1FFF};
    // {first group past memory, group, far link used}
    ptab = '{11'h009, 11'h002, 11'h005, 11'h10A, 11'h10D, 11'h108};
    void'($urandom(91579));
    repeat (6) @(posedge mclk);
    rstn <= 1'h1;
    for (i = 0; i < 4; i++) rd(4'(i * 4), 32'h0, OK, '1);
    rd(4'h2, 32'h0, ERR, '1);
    wr(cell_pkg::STATUS_ADDR, $urandom, ERR);
    $display("test reset_map finished");
    for (j = 0; j < 2; j++)
      for (i = 0; i < 3; i++)
      begin
        v = $urandom;
        wr(ad[i], v, OK);
        rd(ad[i], v & mk[i], OK, mk[i]);
      end
    $display("test readback finished");
    lut = 16'($urandom);
    wr(cell_pkg::LUT_ADDR, {16'h0, lut}, OK);
    wr(cell_pkg::PLACE_ADDR, pl(5'h0, 5'h0, 3'h1), OK);
    for (k = 0; k < 4; k++)
    begin
      wr(cell_pkg::CONFIG_ADDR, cf(2'h0, 2'h3, 2'h3, {5'h10, k[1], k[0], 1'h0}), OK);
      for (j = 0; j < 4; j++)
      begin
        d = 4'($urandom);
        ch = 4'($urandom);
        setin(d, ch);
        o = lut[{d[3], k[1] ? ch[0] : d[2], d[1:0]}];
        chb("local", o, local_out);
        chb("route", o, route_out);
        chb("cascade", k[0] ? (o | ch[2]) : (o & ch[2]), cascade_out);
        chb("carry", 1'h0, carry_out);
      end
    end
    $display("test normal finished");
    wr(cell_pkg::LUT_ADDR, 32'hFAFA, OK);
    wr(cell_pkg::CONFIG_ADDR, cf(2'h0, 2'h3, 2'h3, 8'h84), OK);
    for (i = 0; i < 6; i++)
    begin
      wr(cell_pkg::PLACE_ADDR, pl(ptab[i][10:6], ptab[i][5:1], 3'h0), OK);
      setin(4'h0, 4'h6);
      chb("carry pick", ptab[i][0], local_out);
      setin(4'h1, 4'h6);
      chb("cascade pick", !ptab[i][0], cascade_out);
    end
    $display("test placement finished");
    lut = 16'hE896;
    wr(cell_pkg::LUT_ADDR, {16'h0, lut}, OK);
    wr(cell_pkg::PLACE_ADDR, pl(5'h0, 5'h0, 3'h1), OK);
    wr(cell_pkg::CONFIG_ADDR, cf(2'h1, 2'h3, 2'h3, 8'h80), OK);
    for (j = 0; j < 8; j++)
    begin
      d = 4'($urandom);
      ch = 4'($urandom);
      setin(d, ch);
      chb("sum", d[0] ^ d[1] ^ ch[0], local_out);
      chb("carry out", (d[0] & d[1]) | (ch[0] & (d[0] | d[1])), carry_out);
    end
    $display("test arithmetic finished");
    wr(cell_pkg::CONFIG_ADDR, cf(2'h0, 2'h3, 2'h3, 8'h71), OK);
    for (j = 0; j < 6; j++)
    begin
      d = 4'($urandom);
      if (j == 0) d[0] = 1'h1;
      setin(d, 4'h0);
      tick();
      if (d[0]) q = d[3];
      chb("packed reg", q, route_out);
      chb("table side", lut[d], local_out);
    end
    $display("test packing finished");
    wr(cell_pkg::CONFIG_ADDR, cf(2'h2, 2'h3, 2'h3, 8'h10), OK);
    setin(4'h8, 4'h1);
    tick();
    chb("load", 1'h0, local_out);
    setin(4'h4, 4'h1);
    chb("up carry", 1'h0, carry_out);
    setin(4'h0, 4'h1);
    chb("down carry", 1'h1, carry_out);
    tick();
    chb("count", 1'h1, local_out);
    setin(4'h4, 4'h1);
    chb("up carry", 1'h1, carry_out);
    $display("test counter finished");
    wr(cell_pkg::CONFIG_ADDR, cf(2'h0, 2'h2, 2'h3, 8'h10), OK);
    @(posedge mclk);
    ctrl_logic <= 1'h0;
    settle();
    chb("clear", 1'h0, local_out);
    wr(cell_pkg::CONFIG_ADDR, cf(2'h0, 2'h3, 2'h2, 8'h10), OK);
    settle();
    chb("preset", 1'h1, local_out);
    @(posedge mclk);
    chip_reset_n <= 1'h0;
    settle();
    settle();
    chb("chip reset", 1'h0, local_out);
    @(posedge mclk);
    chip_reset_n <= 1'h1;
    settle();
    chb("preset back", 1'h1, local_out);
    @(posedge mclk);
    ctrl_logic <= 1'h1;
    $display("test clear_preset finished");
    wr(cell_pkg::CONFIG_ADDR, cf(2'h3, 2'h3, 2'h3, 8'h10), OK);
    setin(4'h0, 4'h1);
    tick();
    chb("sync clear", 1'h0, local_out);
    setin(4'h0, 4'h5);
    tick();
    chb("clear count", 1'h1, local_out);
    $display("test clear_counter finished");
    close_out();
  end
endmodule : programmable_logic_cell_test
